// ### hdl/psc_defs.vh
// Constants for the power switchover control block
`ifndef PSC_DEFS_VH
`define PSC_DEFS_VH
`define PSC_ADDR_POWER_CONTROL 8'hc5
`define PSC_ADDR_WRITE_KEY 8'hc1
`define PSC_ADDR_PERIPHERAL_CONFIG 8'hf4
`define PSC_ADDR_SWITCHOVER_CONFIG 8'hf5
`define PSC_ADDR_PM_FLAGS 8'hf8
`define PSC_ADDR_PM_ENABLE 8'hec
`define PSC_ADDR_SCRATCH_THREE 8'hfd
`define PSC_ADDR_SCRATCH_FOUR 8'hfe
`define PSC_ADDR_IRQ_PIN_CONFIG 8'hff
`define PSC_KEY_VALUE 8'ha7
`define PSC_PWR_METER_OFF 6
`define PSC_PWR_CORE_SHUTDOWN 4
`define PSC_PWR_RESERVED_HI 7
`define PSC_PWR_RESET 8'h82
`define PSC_CD_RESET 3'h2
`define PSC_FLAG_RESTORED 7
`define PSC_FLAG_SWITCHOVER 1
`define PSC_PERIPHERAL_CONFIG_SOURCE 6
`define PSC_MODE_FULL 2'h0
`define PSC_MODE_BATTERY 2'h1
`define PSC_MODE_DEEP 2'h2
`endif

// ### hdl/psc_sync.v
// Two-flop level synchroniser
`timescale 1ns/1ps
module psc_sync #(
    parameter RESET_VAL = 1'b0
) (
    input wire clk_sys_i,
    input wire rstn_i,
    input wire d_i,
    output reg q_o
);
    reg meta_q;
    always @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            meta_q <= RESET_VAL;
            q_o <= RESET_VAL;
        end
        else
        begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule

// ### hdl/psc_scratch.v
// Scratch byte store kept across all but a full power loss
`timescale 1ns/1ps
module psc_scratch #(
    parameter WIDTH = 8
) (
    input wire clk_sys_i,
    input wire por_n_i,
    input wire wr_i,
    input wire [WIDTH-1:0] wdata_i,
    output reg [WIDTH-1:0] q_o
);
    always @(posedge clk_sys_i or negedge por_n_i)
    begin
        if (!por_n_i)
            q_o <= {WIDTH{1'b0}};
        else if (wr_i)
            q_o <= wdata_i;
    end
endmodule

// ### hdl/psc_top.v
// Power control register, scratch pads and battery switchover logic
//
// Contract
// - Two eight-bit scratch registers keep contents in every low-power mode.
// - Scratch cleared only on loss of both supplies, not ordinary resets.
// - Metering-off bit switches off modulators and metering logic.
// - Core-shutdown while in battery-run mode stops core, enters deep sleep.
// - Clock divider field gives 4.096 MHz over two to the field; reset 010.
// - Power control write accepted only right after key write of 0xA7.
// - Switched supply fed from main or battery, chosen from enabled triggers.
// - Switchover enabled at reset; upper config bit disables it.
// - Low supervisory input switches to battery when select is 01.
// - Low main supply switches to battery when select is 00 or 01.
// - Battery control pin low or falling forces battery when enabled.
// - Pin function active only when irq pin function is x01.
// - Metering converters unavailable while on battery.
// - Core keeps running, unreset, across supply changes.
// - Switchover and restore events available as enableable interrupts.
// - Return to main only when all enabled triggers are false.
// - With pin enabled, return also needs the pin high.
// - Event flags set regardless of enables, latched until written zero.
`timescale 1ns/1ps
`include "psc_defs.vh"
module psc_top #(
    parameter DATA_W = 8
) (
    input wire clk_sys_i,
    input wire rstn_i,
    input wire por_n_i,
    input wire sfr_wr_i,
    input wire sfr_rd_i,
    input wire [7:0] sfr_addr_i,
    input wire [DATA_W-1:0] sfr_wdata_i,
    input wire main_low_i,
    input wire supervisory_low_i,
    input wire battery_control_pin_i,
    output reg [DATA_W-1:0] sfr_rdata_o,
    output reg use_battery_o,
    output reg supply_source_status_o,
    output reg metering_enable_o,
    output reg core_stop_o,
    output reg [1:0] power_mode_o,
    output reg [2:0] core_clock_divider_o,
    output reg pm_irq_o,
    output reg switch_to_battery_flag_o,
    output reg supply_restored_flag_o
);
    reg [7:0] power_control_q;
    reg key_armed_q;
    reg [1:0] switchover_select_q;
    reg [2:0] ext_irq1_function_q;
    reg enable_restored_q;
    reg enable_switchover_q;
    reg on_battery_q;
    reg on_battery_d;
    reg pin_prev_q;
    reg flag_bso_q;
    reg flag_psr_q;
    reg [1:0] mode_q;
    reg [1:0] mode_d;
    reg [DATA_W-1:0] rdata_d;
    wire main_low_s;
    wire sup_low_s;
    wire pin_s;
    wire [7:0] scratch_pad_three;
    wire [7:0] scratch_pad_four;
    wire wr_pwr;
    wire wr_key;
    wire pin_en;
    wire trig_main;
    wire trig_sup;
    wire trig_pin;
    wire any_trig;
    wire ev_bso;
    wire ev_psr;

    psc_sync #(.RESET_VAL(1'b0)) u_sync_main (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .d_i(main_low_i),
        .q_o(main_low_s)
    );
    psc_sync #(.RESET_VAL(1'b0)) u_sync_sup (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .d_i(supervisory_low_i),
        .q_o(sup_low_s)
    );
    psc_sync #(.RESET_VAL(1'b1)) u_sync_pin (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .d_i(battery_control_pin_i),
        .q_o(pin_s)
    );

    psc_scratch #(.WIDTH(8)) u_scratch_pad_three (
        .clk_sys_i(clk_sys_i),
        .por_n_i(por_n_i),
        .wr_i(sfr_wr_i && sfr_addr_i == `PSC_ADDR_SCRATCH_THREE),
        .wdata_i(sfr_wdata_i[7:0]),
        .q_o(scratch_pad_three)
    );
    psc_scratch #(.WIDTH(8)) u_scratch_pad_four (
        .clk_sys_i(clk_sys_i),
        .por_n_i(por_n_i),
        .wr_i(sfr_wr_i && sfr_addr_i == `PSC_ADDR_SCRATCH_FOUR),
        .wdata_i(sfr_wdata_i[7:0]),
        .q_o(scratch_pad_four)
    );

    assign wr_key = sfr_wr_i && sfr_addr_i == `PSC_ADDR_WRITE_KEY;
    assign wr_pwr = sfr_wr_i && sfr_addr_i == `PSC_ADDR_POWER_CONTROL && key_armed_q;

    // Trigger decode
    assign pin_en = ext_irq1_function_q[1:0] == 2'b01;
    assign trig_main = main_low_s && !switchover_select_q[1];
    assign trig_sup = sup_low_s && switchover_select_q == 2'b01;
    assign trig_pin = pin_en && !switchover_select_q[1] && (!pin_s || pin_prev_q && !pin_s);
    assign any_trig = trig_main || trig_sup || trig_pin;

    always @*
    begin
        on_battery_d = on_battery_q;
        if (switchover_select_q[1])
            on_battery_d = 1'b0;
        else if (any_trig)
            on_battery_d = 1'b1;
        else
            on_battery_d = 1'b0;
    end

    assign ev_bso = on_battery_d && !on_battery_q;
    assign ev_psr = !on_battery_d && on_battery_q;

    always @*
    begin
        mode_d = mode_q;
        case (mode_q)
            `PSC_MODE_FULL:
                if (on_battery_q)
                    mode_d = `PSC_MODE_BATTERY;
            `PSC_MODE_BATTERY:
                if (power_control_q[`PSC_PWR_CORE_SHUTDOWN])
                    mode_d = `PSC_MODE_DEEP;
                else if (!on_battery_q)
                    mode_d = `PSC_MODE_FULL;
            `PSC_MODE_DEEP:
                if (!on_battery_q)
                    mode_d = `PSC_MODE_FULL;
            default:
                mode_d = `PSC_MODE_FULL;
        endcase
    end

    always @*
    begin
        rdata_d = {DATA_W{1'b0}};
        case (sfr_addr_i)
            `PSC_ADDR_POWER_CONTROL: rdata_d[7:0] = power_control_q;
            `PSC_ADDR_SWITCHOVER_CONFIG: rdata_d[1:0] = switchover_select_q;
            `PSC_ADDR_PERIPHERAL_CONFIG: rdata_d[`PSC_PERIPHERAL_CONFIG_SOURCE] = !on_battery_q;
            `PSC_ADDR_PM_FLAGS: rdata_d[7:0] = {flag_psr_q, 5'h00, flag_bso_q, 1'b0};
            `PSC_ADDR_PM_ENABLE: rdata_d[7:0] = {enable_restored_q, 5'h00, enable_switchover_q, 1'b0};
            `PSC_ADDR_IRQ_PIN_CONFIG: rdata_d[7:0] = {3'h0, ext_irq1_function_q, 2'h0};
            `PSC_ADDR_SCRATCH_THREE: rdata_d[7:0] = scratch_pad_three;
            `PSC_ADDR_SCRATCH_FOUR: rdata_d[7:0] = scratch_pad_four;
            default: rdata_d = {DATA_W{1'b0}};
        endcase
    end

    always @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            power_control_q <= `PSC_PWR_RESET;
            key_armed_q <= 1'b0;
            switchover_select_q <= 2'h0;
            ext_irq1_function_q <= 3'h0;
            enable_restored_q <= 1'b0;
            enable_switchover_q <= 1'b0;
            on_battery_q <= 1'b0;
            pin_prev_q <= 1'b1;
            flag_bso_q <= 1'b0;
            flag_psr_q <= 1'b0;
            mode_q <= `PSC_MODE_FULL;
            sfr_rdata_o <= {DATA_W{1'b0}};
            use_battery_o <= 1'b0;
            supply_source_status_o <= 1'b1;
            metering_enable_o <= 1'b1;
            core_stop_o <= 1'b0;
            power_mode_o <= `PSC_MODE_FULL;
            core_clock_divider_o <= `PSC_CD_RESET;
            pm_irq_o <= 1'b0;
            switch_to_battery_flag_o <= 1'b0;
            supply_restored_flag_o <= 1'b0;
        end
        else
        begin
            if (sfr_wr_i)
                key_armed_q <= wr_key && sfr_wdata_i[7:0] == `PSC_KEY_VALUE;
            if (wr_pwr)
                power_control_q <= {1'b1, sfr_wdata_i[6], 1'b0, sfr_wdata_i[4], 1'b0,
                    sfr_wdata_i[2:0]};
            else if (mode_q == `PSC_MODE_DEEP && !on_battery_q)
                power_control_q[`PSC_PWR_CORE_SHUTDOWN] <= 1'b0;
            if (sfr_wr_i && sfr_addr_i == `PSC_ADDR_SWITCHOVER_CONFIG)
                switchover_select_q <= sfr_wdata_i[1:0];
            if (sfr_wr_i && sfr_addr_i == `PSC_ADDR_IRQ_PIN_CONFIG)
                ext_irq1_function_q <= sfr_wdata_i[4:2];
            if (sfr_wr_i && sfr_addr_i == `PSC_ADDR_PM_ENABLE)
            begin
                enable_restored_q <= sfr_wdata_i[`PSC_FLAG_RESTORED];
                enable_switchover_q <= sfr_wdata_i[`PSC_FLAG_SWITCHOVER];
            end
            if (ev_bso)
                flag_bso_q <= 1'b1;
            else if (sfr_wr_i && sfr_addr_i == `PSC_ADDR_PM_FLAGS &&
                !sfr_wdata_i[`PSC_FLAG_SWITCHOVER])
                flag_bso_q <= 1'b0;
            if (ev_psr)
                flag_psr_q <= 1'b1;
            else if (sfr_wr_i && sfr_addr_i == `PSC_ADDR_PM_FLAGS &&
                !sfr_wdata_i[`PSC_FLAG_RESTORED])
                flag_psr_q <= 1'b0;
            on_battery_q <= on_battery_d;
            pin_prev_q <= pin_s;
            mode_q <= mode_d;
            if (sfr_rd_i)
                sfr_rdata_o <= rdata_d;
            use_battery_o <= on_battery_q;
            supply_source_status_o <= !on_battery_q;
            metering_enable_o <= !power_control_q[`PSC_PWR_METER_OFF] && !on_battery_q;
            core_stop_o <= mode_q == `PSC_MODE_DEEP;
            power_mode_o <= mode_q;
            core_clock_divider_o <= power_control_q[2:0];
            pm_irq_o <= (flag_bso_q && enable_switchover_q) ||
                (flag_psr_q && enable_restored_q);
            switch_to_battery_flag_o <= flag_bso_q;
            supply_restored_flag_o <= flag_psr_q;
        end
    end
endmodule

// ### testbench/psc_top_assertions.sv
// Checker for the power switchover control ports
`timescale 1ns/1ps
`include "psc_defs.vh"
module psc_top_chk (
    input wire clk_sys_i,
    input wire rstn_i,
    input wire sfr_wr_i,
    input wire [7:0] sfr_addr_i,
    input wire [7:0] sfr_wdata_i,
    input wire main_low_i,
    input wire use_battery_o,
    input wire supply_source_status_o,
    input wire metering_enable_o,
    input wire core_stop_o,
    input wire [1:0] power_mode_o,
    input wire [2:0] core_clock_divider_o,
    input wire pm_irq_o,
    input wire switch_to_battery_flag_o,
    input wire supply_restored_flag_o
);
    reg key_q;
    wire pw_wr = sfr_wr_i && (sfr_addr_i == `PSC_ADDR_POWER_CONTROL);
    wire fl_clr = sfr_wr_i && (sfr_addr_i == `PSC_ADDR_PM_FLAGS) && !sfr_wdata_i[1];
    // Last bus write was the key
    always @(posedge clk_sys_i or negedge rstn_i)
        if (!rstn_i)
            key_q <= 1'b0;
        else if (sfr_wr_i)
            key_q <= (sfr_addr_i == `PSC_ADDR_WRITE_KEY) && (sfr_wdata_i == `PSC_KEY_VALUE);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    sequence s_go_batt; $rose(use_battery_o); endsequence
    sequence s_flag_up; ##[0:2] switch_to_battery_flag_o; endsequence
    property p_src; use_battery_o && $past(use_battery_o) |-> !supply_source_status_o; endproperty
    property p_meter; use_battery_o && $past(use_battery_o) |-> !metering_enable_o; endproperty
    property p_div; $changed(core_clock_divider_o) |-> $past(pw_wr && key_q) ||
        $past(pw_wr && key_q, 2); endproperty
    property p_key; pw_wr && !key_q |=> $stable(core_clock_divider_o)[*2]; endproperty
    property p_bso; s_go_batt |-> s_flag_up; endproperty
    property p_irq; pm_irq_o |-> switch_to_battery_flag_o || supply_restored_flag_o; endproperty
    property p_clr; $fell(switch_to_battery_flag_o) |-> $past(fl_clr) || $past(fl_clr, 2);
    endproperty
    property p_ret; $fell(use_battery_o) |-> !$past(main_low_i, 3) || !$past(main_low_i, 4);
    endproperty
    property p_core; core_stop_o |-> power_mode_o == `PSC_MODE_DEEP; endproperty
    a_src: assert property (p_src) else $error("source status wrong on battery");
    a_meter: assert property (p_meter) else $error("metering on while on battery");
    a_div: assert property (p_div) else $error("divider changed without keyed write");
    a_key: assert property (p_key) else $error("unkeyed power write accepted");
    a_bso: assert property (p_bso) else $error("switchover flag missing");
    a_irq: assert property (p_irq) else $error("irq without flag");
    a_clr: assert property (p_clr) else $error("flag cleared without write");
    a_ret: assert property (p_ret) else $error("return to main while main low");
    a_core: assert property (p_core) else $error("core stopped outside deep sleep");
endmodule
bind psc_top psc_top_chk u_chk (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .sfr_wr_i(sfr_wr_i),
    .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i), .main_low_i(main_low_i),
    .use_battery_o(use_battery_o), .supply_source_status_o(supply_source_status_o),
    .metering_enable_o(metering_enable_o), .core_stop_o(core_stop_o),
    .power_mode_o(power_mode_o), .core_clock_divider_o(core_clock_divider_o),
    .pm_irq_o(pm_irq_o), .switch_to_battery_flag_o(switch_to_battery_flag_o),
    .supply_restored_flag_o(supply_restored_flag_o));

// ### testbench/psc_core_model.sv
// Processor core model driving the register bus
`timescale 1ns/1ps
`include "psc_defs.vh"
module psc_core_model (
    input wire clk_sys_i,
    input wire [7:0] rdata_i,
    output reg wr_o = 1'b0,
    output reg rd_o = 1'b0,
    output reg [7:0] addr_o = 8'h00,
    output reg [7:0] wdata_o = 8'h00
);
    task sfr_write(input [7:0] a, input [7:0] d);
    begin
        @(posedge clk_sys_i);
        wr_o <= 1'b1;
        addr_o <= a;
        wdata_o <= d;
        @(posedge clk_sys_i);
        wr_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
    end
    endtask
    task sfr_read(input [7:0] a, output [7:0] d);
    begin
        @(posedge clk_sys_i);
        rd_o <= 1'b1;
        addr_o <= a;
        @(posedge clk_sys_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        @(posedge clk_sys_i);
        #1 d = rdata_i;
    end
    endtask
    // Key write right before the power write
    task pwr_write(input [7:0] d);
    begin
        sfr_write(`PSC_ADDR_WRITE_KEY, `PSC_KEY_VALUE);
        sfr_write(`PSC_ADDR_POWER_CONTROL, d);
    end
    endtask
endmodule

// ### testbench/psc_top_tb_top.sv
// Testbench for the power switchover control block
`timescale 1ns/1ps
`include "psc_defs.vh"
module psc_top_tb_top;
    reg clk_sys_i, rstn_i, por_n_i, main_low_i, supervisory_low_i, battery_control_pin_i;
    wire sfr_wr_i, sfr_rd_i, use_battery_o, supply_source_status_o, metering_enable_o;
    wire core_stop_o, pm_irq_o, switch_to_battery_flag_o, supply_restored_flag_o;
    wire [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o;
    wire [1:0] power_mode_o;
    wire [2:0] core_clock_divider_o;
    integer num_errors = 0, total_checks = 0, i;
    psc_core_model core (.clk_sys_i(clk_sys_i), .rdata_i(sfr_rdata_o), .wr_o(sfr_wr_i),
        .rd_o(sfr_rd_i), .addr_o(sfr_addr_i), .wdata_o(sfr_wdata_i));
    psc_top dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .por_n_i(por_n_i),
        .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_addr_i(sfr_addr_i),
        .sfr_wdata_i(sfr_wdata_i), .main_low_i(main_low_i), .supervisory_low_i(supervisory_low_i),
        .battery_control_pin_i(battery_control_pin_i), .sfr_rdata_o(sfr_rdata_o),
        .use_battery_o(use_battery_o), .supply_source_status_o(supply_source_status_o),
        .metering_enable_o(metering_enable_o), .core_stop_o(core_stop_o),
        .power_mode_o(power_mode_o), .core_clock_divider_o(core_clock_divider_o),
        .pm_irq_o(pm_irq_o), .switch_to_battery_flag_o(switch_to_battery_flag_o),
        .supply_restored_flag_o(supply_restored_flag_o));
    initial
    begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    task close_out;
    begin
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    end
    endtask
    task chk(input [7:0] got, input [7:0] exp);
    begin
        total_checks = total_checks + 1;
        if (got !== exp)
        begin
            num_errors = num_errors + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    task rchk(input [7:0] a, input [7:0] e);
        reg [7:0] d;
    begin
        core.sfr_read(a, d);
        chk(d, e);
    end
    endtask
    task wt(input integer n);
    begin
        repeat (n) @(posedge clk_sys_i);
        #1;
    end
    endtask
    task rst(input reg p);
    begin
        rstn_i <= 1'b0;
        por_n_i <= !p;
        repeat (8) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        por_n_i <= 1'b1;
    end
    endtask
    initial
    begin
        #200000;
        num_errors = num_errors + 1;
        close_out;
    end
    initial
    begin
        rstn_i = 1'b0;
        por_n_i = 1'b0;
        main_low_i = 1'b0;
        supervisory_low_i = 1'b0;
        battery_control_pin_i = 1'b1;
        rst(1'b1);
        rchk(`PSC_ADDR_SCRATCH_THREE, 8'h00);
        rchk(`PSC_ADDR_POWER_CONTROL, `PSC_PWR_RESET);
        rchk(8'h80, 8'h00);
        core.sfr_write(`PSC_ADDR_SCRATCH_THREE, 8'h5a);
        core.sfr_write(`PSC_ADDR_SCRATCH_FOUR, 8'ha5);
        rst(1'b0);
        rchk(`PSC_ADDR_SCRATCH_THREE, 8'h5a);
        rchk(`PSC_ADDR_SCRATCH_FOUR, 8'ha5);
        rst(1'b1);
        rchk(`PSC_ADDR_SCRATCH_FOUR, 8'h00);
        core.sfr_write(`PSC_ADDR_POWER_CONTROL, 8'h07);
        core.sfr_write(`PSC_ADDR_WRITE_KEY, `PSC_KEY_VALUE);
        core.sfr_write(`PSC_ADDR_SCRATCH_THREE, 8'h11);
        core.sfr_write(`PSC_ADDR_POWER_CONTROL, 8'h06);
        wt(2);
        chk(core_clock_divider_o, `PSC_CD_RESET);
        for (i = 0; i < 8; i = i + 1)
        begin
            core.pwr_write({5'h00, i[2:0]});
            wt(2);
            chk(core_clock_divider_o, i[7:0]);
            rchk(`PSC_ADDR_POWER_CONTROL, {5'h10, i[2:0]});
        end
        core.pwr_write(8'h42);
        wt(2);
        chk(metering_enable_o, 8'h00);
        core.pwr_write(8'h02);
        core.sfr_write(`PSC_ADDR_PM_ENABLE, 8'h82);
        @(posedge clk_sys_i) main_low_i <= 1'b1;
        wt(8);
        chk(use_battery_o, 8'h01);
        chk(supply_source_status_o, 8'h00);
        chk(metering_enable_o, 8'h00);
        chk(switch_to_battery_flag_o, 8'h01);
        chk(pm_irq_o, 8'h01);
        rchk(`PSC_ADDR_PERIPHERAL_CONFIG, 8'h00);
        core.pwr_write(8'h12);
        wt(2);
        chk(power_mode_o, `PSC_MODE_DEEP);
        chk(core_stop_o, 8'h01);
        @(posedge clk_sys_i) main_low_i <= 1'b0;
        wt(8);
        chk(use_battery_o, 8'h00);
        chk(supply_restored_flag_o, 8'h01);
        chk(power_mode_o, `PSC_MODE_FULL);
        rchk(`PSC_ADDR_PERIPHERAL_CONFIG, 8'h40);
        core.sfr_write(`PSC_ADDR_PM_FLAGS, 8'h00);
        wt(2);
        chk(switch_to_battery_flag_o, 8'h00);
        chk(supply_restored_flag_o, 8'h00);
        chk(pm_irq_o, 8'h00);
        for (i = 0; i < 3; i = i + 1)
        begin
            core.sfr_write(`PSC_ADDR_SWITCHOVER_CONFIG, i[7:0]);
            rchk(`PSC_ADDR_SWITCHOVER_CONFIG, i[7:0]);
            @(posedge clk_sys_i) supervisory_low_i <= 1'b1;
            wt(8);
            chk(use_battery_o, i == 1);
            @(posedge clk_sys_i) main_low_i <= 1'b1;
            wt(8);
            chk(use_battery_o, i != 2);
            @(posedge clk_sys_i) main_low_i <= 1'b0;
            supervisory_low_i <= 1'b0;
            wt(8);
            chk(use_battery_o, 8'h00);
        end
        core.sfr_write(`PSC_ADDR_SWITCHOVER_CONFIG, 8'h00);
        for (i = 0; i < 3; i = i + 1)
        begin
            core.sfr_write(`PSC_ADDR_IRQ_PIN_CONFIG, (i == 0) ? 8'h00 : (i == 1) ? 8'h04 : 8'h14);
            @(posedge clk_sys_i) battery_control_pin_i <= 1'b0;
            wt(8);
            chk(use_battery_o, i != 0);
            @(posedge clk_sys_i) battery_control_pin_i <= 1'b1;
            wt(8);
            chk(use_battery_o, 8'h00);
        end
        close_out;
    end
endmodule
